// file: core/alr_device.sv
// sensor end: two-wire slave, register file and measurement timebase
`timescale 1ns/10ps
`include "alr_defines.svh"
module alr_device import alr_pkg::*; #(
    parameter int IT_BASE_CYCLES = `ALR_IT_BASE_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    alr_if.dev bus,
    input wire logic [15:0] light_level,
    input wire logic [15:0] white_level,
    output logic shutdown,
    output logic [1:0] gain_select,
    output logic [1:0] power_save_mode,
    output logic power_save_enable,
    output logic meas_done
);
    alr_dev_t r_reg, r_next;
    logic rise, fall, start, stop;
    logic [15:0] rd_word;
    logic [7:0] tx_byte;
    logic [5:0] it_ticks;
    logic [3:0] need, nhi, nlo;

    // ==========================================
    // link edge detection
    // the oversampling clock is far above 400 kHz, so any rate down to 10 kHz works
    assign rise = r_reg.scl_s & ~r_reg.scl_d;
    assign fall = ~r_reg.scl_s & r_reg.scl_d;
    assign start = r_reg.scl_s & r_reg.scl_d & r_reg.sda_d & ~r_reg.sda_s;
    assign stop = r_reg.scl_s & r_reg.scl_d & ~r_reg.sda_d & r_reg.sda_s;

    // ==========================================
    // read mux; events are polled here only, there is no interrupt pin
    always_comb begin
        unique case (r_reg.cmd)
            `ALR_CMD_CONFIG: rd_word = r_reg.cfg;
            `ALR_CMD_UPPER: rd_word = r_reg.hi;
            `ALR_CMD_LOWER: rd_word = r_reg.lo;
            `ALR_CMD_PSAVE: rd_word = r_reg.psave;
            `ALR_CMD_AMBIENT: rd_word = r_reg.amb;
            `ALR_CMD_WHITE: rd_word = r_reg.wht;
            `ALR_CMD_STATUS: rd_word = {r_reg.flag_lo, r_reg.flag_hi, 14'h0000};
            default: rd_word = 16'h0000;
        endcase
    end

    // byte about to be sent: low byte first, then high
    always_comb begin
        if (r_reg.st == DS_ACK) begin
            tx_byte = rd_word[7:0];
        end else begin
            tx_byte = r_reg.idx ? rd_word[7:0] : rd_word[15:8];
        end
    end

    // ==========================================
    // measurement setup decode
    always_comb begin
        unique case (r_reg.cfg[`ALR_CFG_IT_LSB +: 4])
            4'b1100: it_ticks = 6'h01;
            4'b1000: it_ticks = 6'h02;
            4'b0000: it_ticks = 6'h04;
            4'b0001: it_ticks = 6'h08;
            4'b0010: it_ticks = 6'h10;
            4'b0011: it_ticks = 6'h20;
            default: it_ticks = 6'h04;
        endcase
    end
    assign need = 4'h1 << r_reg.cfg[`ALR_CFG_PERS_LSB +: 2];
    assign nhi = (r_reg.cnt_hi == 4'h8) ? 4'h8 : r_reg.cnt_hi + 4'h1;
    assign nlo = (r_reg.cnt_lo == 4'h8) ? 4'h8 : r_reg.cnt_lo + 4'h1;

    // ==========================================
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        r_next.scl_m = bus.scl;
        r_next.scl_s = r_reg.scl_m;
        r_next.scl_d = r_reg.scl_s;
        r_next.sda_m = bus.sda;
        r_next.sda_s = r_reg.sda_m;
        r_next.sda_d = r_reg.sda_s;
        if (start) begin
            r_next.st = DS_RX;
            r_next.ph = PH_ADDR;
            r_next.bitc = 4'h0;
            r_next.drive = 1'b0;
        end else if (stop) begin
            r_next.st = DS_IDLE;
            r_next.drive = 1'b0;
        end else begin
            unique case (r_reg.st)
                DS_IDLE: begin
                end
                DS_RX: begin
                    if (rise) begin
                        r_next.sh = {r_reg.sh[6:0], r_reg.sda_s};
                        r_next.bitc = r_reg.bitc + 4'h1;
                    end else if (fall && r_reg.bitc == 4'h8) begin
                        r_next.bitc = 4'h0;
                        r_next.drive = 1'b1;
                        r_next.st = DS_ACK;
                        unique case (r_reg.ph)
                            PH_ADDR: begin
                                if (r_reg.sh[7:1] == `ALR_SLAVE_ADDR) begin
                                    r_next.rw = r_reg.sh[0];
                                    r_next.idx = 1'b0;
                                end else begin
                                    r_next.drive = 1'b0;
                                    r_next.st = DS_IDLE;
                                end
                            end
                            PH_CMD: begin
                                r_next.cmd = r_reg.sh;
                                r_next.idx = 1'b0;
                            end
                            PH_DATA: begin
                                r_next.idx = ~r_reg.idx;
                                if (!r_reg.idx) begin
                                    r_next.wlo = r_reg.sh;
                                end else begin
                                    unique case (r_reg.cmd)
                                        `ALR_CMD_CONFIG: r_next.cfg = {r_reg.sh, r_reg.wlo};
                                        `ALR_CMD_UPPER: r_next.hi = {r_reg.sh, r_reg.wlo};
                                        `ALR_CMD_LOWER: r_next.lo = {r_reg.sh, r_reg.wlo};
                                        `ALR_CMD_PSAVE: r_next.psave = {r_reg.sh, r_reg.wlo};
                                        default: begin
                                        end
                                    endcase
                                end
                            end
                            default: r_next.st = DS_IDLE;
                        endcase
                    end
                end
                DS_ACK: begin
                    if (fall) begin
                        r_next.drive = 1'b0;
                        if (r_reg.ph == PH_ADDR && r_reg.rw) begin
                            r_next.st = DS_TX;
                            r_next.sh = tx_byte;
                            r_next.drive = ~tx_byte[7];
                        end else begin
                            r_next.st = DS_RX;
                            r_next.ph = (r_reg.ph == PH_ADDR) ? PH_CMD : PH_DATA;
                        end
                    end
                end
                DS_TX: begin
                    if (rise) begin
                        r_next.bitc = r_reg.bitc + 4'h1;
                    end else if (fall) begin
                        if (r_reg.bitc == 4'h8) begin
                            r_next.bitc = 4'h0;
                            r_next.drive = 1'b0;
                            r_next.st = DS_TXACK;
                        end else begin
                            r_next.sh = {r_reg.sh[6:0], 1'b0};
                            r_next.drive = ~r_reg.sh[6];
                        end
                    end
                end
                DS_TXACK: begin
                    if (rise) begin
                        r_next.nack = r_reg.sda_s;
                    end else if (fall) begin
                        if (r_reg.nack) begin
                            r_next.st = DS_IDLE;
                        end else begin
                            r_next.idx = ~r_reg.idx;
                            r_next.st = DS_TX;
                            r_next.sh = tx_byte;
                            r_next.drive = ~tx_byte[7];
                            // handing out the status high byte consumes the flags
                            if (!r_reg.idx && r_reg.cmd == `ALR_CMD_STATUS) begin
                                r_next.flag_lo = 1'b0;
                                r_next.flag_hi = 1'b0;
                            end
                        end
                    end
                end
                default: r_next.st = DS_IDLE;
            endcase
        end
        // measurement runs after the bus logic so a new event beats a clear
        if (r_reg.cfg[`ALR_CFG_SD]) begin
            r_next.tcnt = 32'h0000_0000;
            r_next.ticks = 6'h00;
        end else if (r_reg.tcnt == 32'(IT_BASE_CYCLES - 1)) begin
            r_next.tcnt = 32'h0000_0000;
            if (6'(r_reg.ticks + 6'h01) >= it_ticks) begin
                r_next.ticks = 6'h00;
                r_next.done = 1'b1;
                r_next.amb = light_level;
                r_next.wht = white_level;
                if (r_reg.cfg[`ALR_CFG_INT_EN]) begin
                    r_next.cnt_hi = (light_level > r_reg.hi) ? nhi : 4'h0;
                    r_next.cnt_lo = (light_level < r_reg.lo) ? nlo : 4'h0;
                    if (light_level > r_reg.hi && nhi >= need) begin
                        r_next.flag_hi = 1'b1;
                    end
                    if (light_level < r_reg.lo && nlo >= need) begin
                        r_next.flag_lo = 1'b1;
                    end
                end else begin
                    r_next.cnt_hi = 4'h0;
                    r_next.cnt_lo = 4'h0;
                end
            end else begin
                r_next.ticks = r_reg.ticks + 6'h01;
            end
        end else begin
            r_next.tcnt = r_reg.tcnt + 32'h0000_0001;
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
            r_reg.cfg <= `ALR_CONFIG_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe_n = ~r_reg.drive;
    assign shutdown = r_reg.cfg[`ALR_CFG_SD];
    assign gain_select = r_reg.cfg[`ALR_CFG_GAIN_LSB +: 2];
    assign power_save_mode = r_reg.psave[2:1];
    assign power_save_enable = r_reg.psave[0];
    assign meas_done = r_reg.done;
endmodule

// file: core/alr_defines.svh
// shared constants of the light sensor register link
`ifndef ALR_DEFINES_SVH
`define ALR_DEFINES_SVH
// ==========================================
// bus addressing
`define ALR_SLAVE_ADDR 7'h10
`define ALR_ADDR_WR 8'h20
`define ALR_ADDR_RD 8'h21
// ==========================================
// command codes
`define ALR_CMD_CONFIG 8'h00
`define ALR_CMD_UPPER 8'h01
`define ALR_CMD_LOWER 8'h02
`define ALR_CMD_PSAVE 8'h03
`define ALR_CMD_AMBIENT 8'h04
`define ALR_CMD_WHITE 8'h05
`define ALR_CMD_STATUS 8'h06
// ==========================================
// fields and reset values
`define ALR_CONFIG_RESET 16'h0001
`define ALR_CFG_SD 0
`define ALR_CFG_INT_EN 1
`define ALR_CFG_PERS_LSB 4
`define ALR_CFG_IT_LSB 6
`define ALR_CFG_GAIN_LSB 11
`define ALR_CFG_MASK 16'h1bf3
`define ALR_PSAVE_MASK 16'h0007
`define ALR_STAT_LOW_BIT 15
`define ALR_STAT_HIGH_BIT 14
// ==========================================
// timing
`define ALR_CLK_KHZ 100000
`define ALR_SCL_MIN_KHZ 10
`define ALR_SCL_MAX_KHZ 400
`define ALR_QTR_CYCLES ((`ALR_CLK_KHZ + 4 * `ALR_SCL_MAX_KHZ - 1) / (4 * `ALR_SCL_MAX_KHZ))
`define ALR_IT_BASE_MS 25
`define ALR_IT_BASE_CYCLES (`ALR_IT_BASE_MS * `ALR_CLK_KHZ)
// ==========================================
// host command port offsets
`define ALR_H_CMD 3'h0
`define ALR_H_WDATA 3'h1
`define ALR_H_CTRL 3'h2
`define ALR_H_RDATA 3'h3
`define ALR_H_STAT 3'h4
`endif

// file: core/alr_pkg.sv
// types shared by both ends of the light sensor link
package alr_pkg;
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0, DS_RX = 3'h1, DS_ACK = 3'h2, DS_TX = 3'h3, DS_TXACK = 3'h4
    } alr_dev_state_t;
    typedef enum logic [1:0] {PH_ADDR = 2'h0, PH_CMD = 2'h1, PH_DATA = 2'h2} alr_phase_t;
    typedef enum logic [1:0] {
        HS_IDLE = 2'h0, HS_STA = 2'h1, HS_BIT = 2'h2, HS_STO = 2'h3
    } alr_host_state_t;
    typedef struct packed {
        alr_dev_state_t st;
        alr_phase_t ph;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic rw, idx, drive, nack;
        logic [7:0] cmd, wlo;
        logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
        logic [15:0] cfg, hi, lo, psave, amb, wht;
        logic flag_lo, flag_hi;
        logic [31:0] tcnt;
        logic [5:0] ticks;
        logic [3:0] cnt_hi, cnt_lo;
        logic done;
    } alr_dev_t;
    typedef struct packed {
        alr_host_state_t st;
        logic [1:0] q;
        logic [7:0] qcnt;
        logic [3:0] bitc;
        logic [2:0] bytec;
        logic [8:0] sh;
        logic samp, rd_op, busy, nack, scl_lo, sda_lo, sda_m, sda_s;
        logic [7:0] cmd;
        logic [15:0] wdata, rdata, rdout;
    } alr_host_t;
endpackage

// file: core/alr_if.sv
// open-drain two-wire link between host and sensor
`timescale 1ns/10ps
interface alr_if;
    logic host_scl_o;
    logic host_scl_oe_n;
    logic host_sda_o;
    logic host_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;
    // pull-ups: a line is low only while some end enables a low drive
    assign scl = host_scl_oe_n | host_scl_o;
    assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
    modport host (output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, input scl, sda);
    modport dev (output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface

// file: core/alr_host.sv
// host end: two-wire master driven from a small command port
`timescale 1ns/10ps
`include "alr_defines.svh"
module alr_host import alr_pkg::*; #(
    parameter int QTR_CYCLES = `ALR_QTR_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    alr_if.host bus,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    alr_host_t r_reg, r_next;
    logic tick, rx_byte;
    logic [15:0] wmask;
    logic [8:0] nsh, frame;

    // ==========================================
    // quarter-bit enable, rounded so the line never beats 400 kHz
    assign tick = (r_reg.qcnt == 8'(QTR_CYCLES - 1));
    assign rx_byte = r_reg.rd_op && r_reg.bytec >= 3'h3;
    assign nsh = {r_reg.sh[7:0], r_reg.samp};

    // reserved bits forced to zero on the wire
    always_comb begin
        unique case (r_reg.cmd)
            `ALR_CMD_CONFIG: wmask = r_reg.wdata & `ALR_CFG_MASK;
            `ALR_CMD_PSAVE: wmask = r_reg.wdata & `ALR_PSAVE_MASK;
            default: wmask = r_reg.wdata;
        endcase
    end

    // frame of the byte after the current one; ninth bit is the ack slot
    always_comb begin
        unique case (3'(r_reg.bytec + 3'h1))
            3'h1: frame = {r_reg.cmd, 1'b1};
            3'h2: frame = r_reg.rd_op ? {`ALR_ADDR_RD, 1'b1} : {wmask[7:0], 1'b1};
            3'h3: frame = r_reg.rd_op ? {8'hff, 1'b0} : {wmask[15:8], 1'b1};
            default: frame = {8'hff, 1'b1};
        endcase
    end

    // ==========================================
    // next state
    always_comb begin
        r_next = r_reg;
        r_next.sda_m = bus.sda;
        r_next.sda_s = r_reg.sda_m;
        if (reg_rd) begin
            unique case (reg_addr)
                `ALR_H_CMD: r_next.rdout = {8'h00, r_reg.cmd};
                `ALR_H_WDATA: r_next.rdout = r_reg.wdata;
                `ALR_H_RDATA: r_next.rdout = r_reg.rdata;
                `ALR_H_STAT: r_next.rdout = {14'h0000, r_reg.nack, r_reg.busy};
                default: r_next.rdout = 16'h0000;
            endcase
        end
        // a new command is refused while a transfer runs
        if (reg_wr && !r_reg.busy) begin
            unique case (reg_addr)
                `ALR_H_CMD: r_next.cmd = reg_wdata[7:0];
                `ALR_H_WDATA: r_next.wdata = reg_wdata;
                `ALR_H_CTRL: begin
                    if (reg_wdata[1:0] != 2'b00) begin
                        r_next.busy = 1'b1;
                        r_next.nack = 1'b0;
                        r_next.rd_op = reg_wdata[1];
                        r_next.st = HS_STA;
                        r_next.q = 2'h0;
                        r_next.qcnt = 8'h00;
                        r_next.bytec = 3'h0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (r_reg.st != HS_IDLE) begin
            r_next.qcnt = tick ? 8'h00 : r_reg.qcnt + 8'h01;
        end
        if (tick && r_reg.st != HS_IDLE) begin
            r_next.q = r_reg.q + 2'h1;
            unique case (r_reg.st)
                HS_STA: begin
                    unique case (r_reg.q)
                        2'h0: begin
                            r_next.sda_lo = 1'b0;
                            r_next.scl_lo = 1'b1;
                        end
                        2'h1: r_next.scl_lo = 1'b0;
                        2'h2: r_next.sda_lo = 1'b1;
                        2'h3: begin
                            r_next.scl_lo = 1'b1;
                            r_next.st = HS_BIT;
                            r_next.bitc = 4'h0;
                            r_next.sh = (r_reg.bytec == 3'h0) ? {`ALR_ADDR_WR, 1'b1}
                                                              : {`ALR_ADDR_RD, 1'b1};
                        end
                    endcase
                end
                HS_BIT: begin
                    unique case (r_reg.q)
                        2'h0: r_next.sda_lo = ~r_reg.sh[8];
                        2'h1: r_next.scl_lo = 1'b0;
                        2'h2: r_next.samp = r_reg.sda_s;
                        2'h3: begin
                            r_next.scl_lo = 1'b1;
                            r_next.sh = nsh;
                            r_next.bitc = r_reg.bitc + 4'h1;
                            if (r_reg.bitc == 4'h8) begin
                                r_next.bitc = 4'h0;
                                r_next.bytec = r_reg.bytec + 3'h1;
                                r_next.sh = frame;
                                if (r_reg.bytec == 3'h3 && r_reg.rd_op) begin
                                    r_next.rdata[7:0] = nsh[8:1];
                                end
                                if (r_reg.bytec == 3'h4) begin
                                    r_next.rdata[15:8] = nsh[8:1];
                                end
                                if (!rx_byte && r_reg.samp) begin
                                    r_next.nack = 1'b1;
                                    r_next.st = HS_STO;
                                end else if (r_reg.rd_op && r_reg.bytec == 3'h1) begin
                                    r_next.st = HS_STA;
                                end else if (r_reg.bytec == (r_reg.rd_op ? 3'h4 : 3'h3)) begin
                                    r_next.st = HS_STO;
                                end
                            end
                        end
                    endcase
                end
                HS_STO: begin
                    unique case (r_reg.q)
                        2'h0: r_next.sda_lo = 1'b1;
                        2'h1: r_next.scl_lo = 1'b0;
                        2'h2: r_next.sda_lo = 1'b0;
                        2'h3: begin
                            r_next.st = HS_IDLE;
                            r_next.busy = 1'b0;
                        end
                    endcase
                end
                default: r_next.st = HS_IDLE;
            endcase
        end
    end

    // ==========================================
    // state register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus.host_scl_o = 1'b0;
    assign bus.host_scl_oe_n = ~r_reg.scl_lo;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe_n = ~r_reg.sda_lo;
    assign reg_rdata = r_reg.rdout;
endmodule

// file: test/alr_props.sv
// checker on the open-drain link between host and sensor
`timescale 1ns/10ps
module alr_props #(
    parameter int QTR_CYCLES = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic host_scl_o,
    input wire logic host_scl_oe_n,
    input wire logic host_sda_o,
    input wire logic host_sda_oe_n,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe_n,
    input wire logic scl,
    input wire logic sda
);
    // ====
    // clock phase lengths
    logic [15:0] hi_cnt_reg;
    logic [15:0] lo_cnt_reg;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt_reg <= 16'h0000;
            lo_cnt_reg <= 16'h0000;
        end else begin
            hi_cnt_reg <= scl ? hi_cnt_reg + 16'h0001 : 16'h0000;
            lo_cnt_reg <= scl ? 16'h0000 : lo_cnt_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // ====
    // properties
    a_open_drain: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("driven high level on link");
    a_dev_moves_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("sensor moved data while clock high");
    a_start_by_host: assert property (($fell(sda) && scl && $past(scl)) |-> !host_sda_oe_n)
        else $error("start not made by host");
    a_stop_by_host: assert property (($rose(sda) && scl && $past(scl)) |->
        $past(dev_sda_oe_n))
        else $error("sensor released data in clock high");
    a_scl_high_min: assert property ($fell(scl) |-> hi_cnt_reg >= QTR_CYCLES)
        else $error("clock high too short");
    a_scl_low_min: assert property ($rose(scl) |-> lo_cnt_reg >= QTR_CYCLES)
        else $error("clock low too short");
    a_scl_low_max: assert property (lo_cnt_reg <= 8 * QTR_CYCLES)
        else $error("clock low too long");
    a_reset_idle: assert property ($rose(arst_n) |->
        host_scl_oe_n && host_sda_oe_n && dev_sda_oe_n)
        else $error("link not released after reset");
endmodule

// file: test/tb_top.sv
// bench: host command port drives word transfers to the sensor
`timescale 1ns/10ps
`include "alr_defines.svh"
module tb_top;
    logic clk, arst_n, reg_wr, reg_rd, shutdown, pse, meas_done;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, light, white, d;
    logic [1:0] gain, ps_mode;
    int err_total, num_checks, n;
    alr_if ifc();
    alr_device #(.IT_BASE_CYCLES(20)) alr_device_i (.clk(clk), .arst_n(arst_n), .bus(ifc),
        .light_level(light), .white_level(white), .shutdown(shutdown), .gain_select(gain),
        .power_save_mode(ps_mode), .power_save_enable(pse), .meas_done(meas_done));
    alr_host #(.QTR_CYCLES(8)) alr_host_i (.clk(clk), .arst_n(arst_n), .bus(ifc),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    alr_props #(.QTR_CYCLES(8)) alr_props_i (.clk(clk), .arst_n(arst_n),
        .host_scl_o(ifc.host_scl_o), .host_scl_oe_n(ifc.host_scl_oe_n),
        .host_sda_o(ifc.host_sda_o), .host_sda_oe_n(ifc.host_sda_oe_n),
        .dev_sda_o(ifc.dev_sda_o), .dev_sda_oe_n(ifc.dev_sda_oe_n),
        .scl(ifc.scl), .sda(ifc.sda));
    // ====
    // tasks
    task automatic end_of_test();
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic stuck(input bit hit);
        if (hit) begin
            err_total++;
            end_of_test();
        end
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        // read data stand in the cycle after the strobe; take them at its closing edge
        @(posedge clk);
        d = reg_rdata;
    endtask
    // one word over the link; ctl 1 writes, 2 reads into d
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] v, input logic [15:0] ctl);
        wr(`ALR_H_CMD, {8'h00, cmd});
        wr(`ALR_H_WDATA, v);
        wr(`ALR_H_CTRL, ctl);
        d = 16'h0001;
        for (n = 0; n < 2000 && d[0] !== 1'b0; n++) rd(`ALR_H_STAT);
        stuck(n == 2000);
        chk({14'h0000, d[1:0]}, 16'h0000);
        if (ctl[1]) rd(`ALR_H_RDATA);
    endtask
    // results move only at measurement end, so wait for its pulse
    task automatic waitm();
        for (n = 0; n < 500; n++) begin
            @(posedge clk);
            if (meas_done === 1'b1) break;
        end
        stuck(n == 500);
    endtask
    // ====
    // sequence
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        light = 16'h2000;
        white = 16'ha55a;
        err_total = 0;
        num_checks = 0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk({15'h0000, shutdown}, 16'h0001);
        xfer(`ALR_CMD_CONFIG, 16'h0000, 16'h0002);
        chk(d, 16'h0001);
        xfer(`ALR_CMD_UPPER, 16'h1234, 16'h0001);
        xfer(`ALR_CMD_LOWER, 16'h0010, 16'h0001);
        xfer(`ALR_CMD_PSAVE, 16'hfff5, 16'h0001);
        chk({13'h0000, ps_mode, pse}, 16'h0005);
        xfer(`ALR_CMD_UPPER, 16'h0000, 16'h0002);
        chk(d, 16'h1234);
        xfer(`ALR_CMD_LOWER, 16'h0000, 16'h0002);
        chk(d, 16'h0010);
        xfer(`ALR_CMD_CONFIG, 16'hef0e, 16'h0001);
        chk({13'h0000, gain, shutdown}, 16'h0002);
        xfer(`ALR_CMD_CONFIG, 16'h0000, 16'h0002);
        chk(d, 16'h0b02);
        waitm();
        xfer(`ALR_CMD_AMBIENT, 16'h0000, 16'h0002);
        chk(d, 16'h2000);
        xfer(`ALR_CMD_WHITE, 16'h0000, 16'h0002);
        chk(d, 16'ha55a);
        light <= 16'h0100;
        waitm();
        waitm();
        xfer(`ALR_CMD_STATUS, 16'h0000, 16'h0002);
        chk(d, 16'h4000);
        xfer(`ALR_CMD_STATUS, 16'h0000, 16'h0002);
        chk(d, 16'h0000);
        xfer(`ALR_CMD_CONFIG, 16'h0b03, 16'h0001);
        chk({15'h0000, shutdown}, 16'h0001);
        light <= 16'h0005;
        xfer(`ALR_CMD_AMBIENT, 16'h0000, 16'h0002);
        chk(d, 16'h0100);
        // wake at the 100 ms code: four base periods of 20 clocks between results
        xfer(`ALR_CMD_CONFIG, 16'h0802, 16'h0001);
        waitm();
        waitm();
        chk(n[15:0], 16'h004f);
        xfer(`ALR_CMD_AMBIENT, 16'h0000, 16'h0002);
        chk(d, 16'h0005);
        xfer(`ALR_CMD_STATUS, 16'h0000, 16'h0002);
        chk(d, 16'h8000);
        xfer(8'h07, 16'h0000, 16'h0002);
        chk(d, 16'h0000);
        rd(3'h7);
        chk(d, 16'h0000);
        end_of_test();
    end
endmodule
